// >>> src/link_init_host.sv
`timescale 1ns/1ps
// Summary of operation
// - host releases powerdown after supplies settle
// - powerdown held low at least 2 ms
// - lock within 15 ms typical, 22 max
// - soft reset bit resets logic, self-clears
// - wrong bring-up order: host resets device (host here only holds powerdown low until supplies settle, no later check)
// - on lock loss host applies reset
// - lock loss restarts equaliser and acquisition
// - software may force a fixed equaliser level
// host end: pulses powerdown, watches lock, recovers on loss or timeout
module link_init_host
   import link_init_pkg::*;
#(
   parameter int unsigned PD_LOW_CYCLES = PD_LOW_CYC,    // powerdown low time
   parameter int unsigned LOCK_CYCLES   = LOCK_MAX_CYC   // lock timeout
)
(
   input  wire logic         sys_clk_i,          // system clock
   input  wire logic         rstn_i,             // async reset, low active
   input  wire logic         supplies_good_i,    // rails settled
   input  wire logic         use_soft_reset_i,   // recover by soft reset
   input  wire logic         eq_manual_i,        // request fixed level
   input  wire logic [3:0]   eq_level_i,         // fixed level wanted
   output logic              link_up_o,          // link locked
   output logic              fail_o,             // one-cycle timeout pulse
   link_init_if.host         lnk
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      H_OFF    = 3'b000,  // waiting for supplies
      H_PDLOW  = 3'b001,  // holding powerdown low
      H_WAIT   = 3'b010,  // waiting for lock
      H_UP     = 3'b011,  // link up
      H_SOFT   = 3'b100,  // issuing soft reset
      H_EQ     = 3'b101   // writing equaliser controls
   } hstate_t;

   typedef struct packed
   {
      hstate_t          st;
      logic [CTR_W-1:0] ctr;
      logic [1:0]       lk_s;    // lock synchroniser
      logic [1:0]       sg_s;    // supplies synchroniser
      logic             pd_n;
      logic             stb;
      logic [7:0]       addr;
      logic [7:0]       data;
      logic             eq_step;
      logic             up;
      logic             fail;
   } hreg_t;

   hreg_t q;
   hreg_t d;

   assign lnk.powerdown_pin_n = q.pd_n;
   assign lnk.wr_stb          = q.stb;
   assign lnk.wr_addr         = q.addr;
   assign lnk.wr_data         = q.data;
   assign link_up_o           = q.up;
   assign fail_o              = q.fail;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d       = q;
      d.lk_s  = {q.lk_s[0], lnk.lock};
      d.sg_s  = {q.sg_s[0], supplies_good_i};
      d.stb   = 1'b0;
      d.fail  = 1'b0;
      d.ctr   = q.ctr + 1'b1;
      case (q.st)
         H_OFF:
         begin
            // release only after rails are stable
            d.pd_n = 1'b0;
            d.ctr  = '0;
            if (q.sg_s[1])
               d.st = H_PDLOW;
         end
         H_PDLOW:
         begin
            // hold low the least pulse width
            d.pd_n = 1'b0;
            if (q.ctr >= CTR_W'(PD_LOW_CYCLES - 1))
            begin
               d.pd_n = 1'b1;
               d.ctr  = '0;
               d.st   = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // give up after the longest lock time
            if (q.lk_s[1])
            begin
               d.st      = H_EQ;
               d.eq_step = 1'b0;
            end
            else if (q.ctr >= CTR_W'(LOCK_CYCLES - 1))
            begin
               d.fail = 1'b1;
               d.ctr  = '0;
               d.st   = use_soft_reset_i ? H_SOFT : H_PDLOW;
               d.pd_n = use_soft_reset_i;
            end
         end
         H_EQ:
         begin
            // two writes: fixed level, then bypass select
            d.stb = 1'b1;
            if (!q.eq_step)
            begin
               d.addr    = EQ_CTRL_ADDR;
               d.data    = {4'h0, eq_level_i};
               d.eq_step = 1'b1;
            end
            else
            begin
               d.addr = EQ_MODE_ADDR;
               d.data = 8'(eq_manual_i) << EQ_BYPASS_BIT;
               d.up   = 1'b1;
               d.st   = H_UP;
            end
         end
         H_UP:
         begin
            // lock dropped: recover
            if (!q.lk_s[1])
            begin
               d.up   = 1'b0;
               d.ctr  = '0;
               d.st   = use_soft_reset_i ? H_SOFT : H_PDLOW;
               d.pd_n = use_soft_reset_i;
            end
         end
         H_SOFT:
         begin
            // self-clearing soft reset write
            d.stb  = 1'b1;
            d.addr = CTRL_RESET_ADDR;
            d.data = 8'(1) << SOFT_RESET_BIT;
            d.ctr  = '0;
            d.st   = H_WAIT;
         end
         default:
         begin
            d.st = H_OFF;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         q <= '{st: H_OFF, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

endmodule

// >>> shared/link_init_pkg.sv
package link_init_pkg;

   // ----------------------------------------------------------------
   // timing figures, in their own units, and derived cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 200;   // system clock rate
   localparam int unsigned PD_LOW_MIN_MS    = 2;     // least low pulse on powerdown
   localparam int unsigned LOCK_TYP_MS      = 15;    // typical lock time
   localparam int unsigned LOCK_MAX_MS      = 22;    // longest lock time
   localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
   localparam int unsigned PD_LOW_CYC       = PD_LOW_MIN_MS * CYC_PER_MS;
   localparam int unsigned LOCK_TYP_CYC     = LOCK_TYP_MS * CYC_PER_MS;
   localparam int unsigned LOCK_MAX_CYC     = LOCK_MAX_MS * CYC_PER_MS;

   // ----------------------------------------------------------------
   // control port layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET_ADDR   = 8'h01;  // control register 0x01
   localparam int unsigned SOFT_RESET_BIT   = 1;      // self-clearing soft reset
   localparam logic [7:0] EQ_CTRL_ADDR      = 8'h04;  // manual equaliser level
   localparam logic [7:0] EQ_MODE_ADDR      = 8'h4D;  // equaliser bypass select
   localparam int unsigned EQ_BYPASS_BIT    = 6;      // use manual level when set
   localparam int unsigned EQ_W             = 4;      // equaliser level width
   localparam logic [3:0] EQ_RESET_LEVEL    = 4'h0;   // level after adapt restart
   localparam logic [3:0] EQ_MAX_LEVEL      = 4'hF;   // strongest level
   localparam int unsigned CTR_W            = 23;     // wide enough for 22 ms
   localparam logic [7:0] CTRL_RESET_VALUE  = 8'h00;  // value after reset

endpackage

// >>> shared/link_init_if.sv
`timescale 1ns/1ps
interface link_init_if;
   logic       powerdown_pin_n;  // powerdown, low holds device in reset
   logic       lock;             // device has data lock
   logic       wr_stb;           // one-cycle control port write
   logic [7:0] wr_addr;          // control register address
   logic [7:0] wr_data;          // control register data
   logic [3:0] eq_level;         // equaliser level in use

   modport device
   (
      input  powerdown_pin_n,
      input  wr_stb,
      input  wr_addr,
      input  wr_data,
      output lock,
      output eq_level
   );

   modport host
   (
      output powerdown_pin_n,
      output wr_stb,
      output wr_addr,
      output wr_data,
      input  lock,
      input  eq_level
   );
endinterface

// >>> src/link_init_device.sv
`timescale 1ns/1ps
// device end: leaves powerdown, acquires lock, obeys control writes
module link_init_device
   import link_init_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_TYP_CYC   // acquisition time
)
(
   input  wire logic         sys_clk_i,      // system clock
   input  wire logic         rstn_i,         // async reset, low active
   input  wire logic         signal_ok_i,    // serial input carries a signal
   output logic              soft_rst_o,     // one-cycle digital reset pulse
   output logic [7:0]        ctrl_reg_o,     // control register 0x01 contents
   link_init_if.device       lnk
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      D_DOWN  = 2'b00,   // powered down
      D_ACQ   = 2'b01,   // adapting and acquiring
      D_LOCK  = 2'b10    // locked
   } dstate_t;

   typedef struct packed
   {
      dstate_t          st;
      logic [CTR_W-1:0] ctr;
      logic [1:0]       pd_s;     // powerdown synchroniser
      logic [1:0]       sig_s;    // signal synchroniser
      logic [7:0]       ctrl;     // register 0x01, survives soft reset
      logic [3:0]       eq_man;   // manual level, survives soft reset
      logic             bypass;   // manual level in force
      logic [3:0]       eq_adapt; // adaptive level
      logic             lock;
      logic             srst;
      logic [3:0]       eq_out;   // level shown on the port
   } dreg_t;

   dreg_t q;
   dreg_t d;

   logic wr_ok;   // write accepted only while powered

   assign wr_ok      = lnk.wr_stb && q.pd_s[1];
   assign lnk.lock     = q.lock;
   assign lnk.eq_level = q.eq_out;
   assign soft_rst_o = q.srst;
   assign ctrl_reg_o = q.ctrl;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d       = q;
      d.pd_s  = {q.pd_s[0], lnk.powerdown_pin_n};
      d.sig_s = {q.sig_s[0], signal_ok_i};
      d.srst  = 1'b0;
      d.ctr   = q.ctr + 1'b1;
      // register writes; soft reset bit never stored
      if (wr_ok && lnk.wr_addr == CTRL_RESET_ADDR)
      begin
         d.ctrl = lnk.wr_data & ~(8'(1) << SOFT_RESET_BIT);
         d.srst = lnk.wr_data[SOFT_RESET_BIT];
      end
      if (wr_ok && lnk.wr_addr == EQ_CTRL_ADDR)
         d.eq_man = lnk.wr_data[EQ_W-1:0];
      if (wr_ok && lnk.wr_addr == EQ_MODE_ADDR)
         d.bypass = lnk.wr_data[EQ_BYPASS_BIT];
      case (q.st)
         D_DOWN:
         begin
            // leave powerdown on pin release
            d.lock = 1'b0;
            d.ctr  = '0;
            if (q.pd_s[1])
               d.st = D_ACQ;
         end
         D_ACQ:
         begin
            // sweep the adaptive level while acquiring
            d.lock = 1'b0;
            if (!q.sig_s[1])
               d.ctr = '0;
            else if (q.ctr >= CTR_W'(LOCK_CYCLES - 1))
            begin
               d.lock = 1'b1;
               d.st   = D_LOCK;
            end
            else if (q.ctr[7:0] == 8'hFF && q.eq_adapt != EQ_MAX_LEVEL)
               d.eq_adapt = q.eq_adapt + 4'h1;
         end
         D_LOCK:
         begin
            // signal lost: reset equaliser and reacquire
            if (!q.sig_s[1])
            begin
               d.lock     = 1'b0;
               d.eq_adapt = EQ_RESET_LEVEL;
               d.ctr      = '0;
               d.st       = D_ACQ;
            end
         end
         default:
         begin
            d.st = D_DOWN;
         end
      endcase
      // soft reset restarts logic, registers kept
      if (q.srst)
      begin
         d.st       = D_ACQ;
         d.lock     = 1'b0;
         d.ctr      = '0;
         d.eq_adapt = EQ_RESET_LEVEL;
      end
      // powerdown resets everything
      if (!q.pd_s[1])
      begin
         d.st       = D_DOWN;
         d.lock     = 1'b0;
         d.ctrl     = CTRL_RESET_VALUE;
         d.eq_man   = EQ_RESET_LEVEL;
         d.bypass   = 1'b0;
         d.eq_adapt = EQ_RESET_LEVEL;
         d.srst     = 1'b0;
      end
      // port level from a flop, so no mux glitch reaches the pin
      d.eq_out = d.bypass ? d.eq_man : d.eq_adapt;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         q <= '{st: D_DOWN, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

endmodule

// >>> test/link_init_sva.sv
`timescale 1ns/1ps
// watches the host/device interface as plain signals
module link_init_sva
   import link_init_pkg::*;
#(
   parameter int unsigned PD_LOW    = 10,   // host powerdown low cycles, as in the bench
   parameter int unsigned LOCK_DEV  = 600,  // device acquisition cycles, as in the bench
   parameter int unsigned LOCK_HOST = 700   // host lock timeout cycles, as in the bench
)
(
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       powerdown_pin_n,
   input  wire logic       lock,
   input  wire logic       wr_stb,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic [3:0] eq_level
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic        soft_wr;   // soft reset write on the port
   int unsigned lo_q;      // cycles powerdown low
   int unsigned hi_q;      // cycles powerdown high
   int unsigned wait_q;    // cycles waiting for lock, no recovery
   logic [3:0]  man_q;     // manual level written
   logic        byp_q;     // bypass written

   assign soft_wr = wr_stb && wr_addr == CTRL_RESET_ADDR && wr_data[SOFT_RESET_BIT];

   // counters and a mirror of the equaliser controls
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lo_q   <= 0;
         hi_q   <= 0;
         wait_q <= 0;
         man_q  <= 4'h0;
         byp_q  <= 1'b0;
      end
      else
      begin
         lo_q   <= powerdown_pin_n ? 0 : lo_q + 1;
         hi_q   <= powerdown_pin_n ? hi_q + 1 : 0;
         wait_q <= (!powerdown_pin_n || lock || soft_wr) ? 0 : wait_q + 1;
         if (!powerdown_pin_n)
         begin
            man_q <= 4'h0;
            byp_q <= 1'b0;
         end
         else if (wr_stb && wr_addr == EQ_CTRL_ADDR)
            man_q <= wr_data[3:0];
         else if (wr_stb && wr_addr == EQ_MODE_ADDR)
            byp_q <= wr_data[EQ_BYPASS_BIT];
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_pd_low_min;
      $rose(powerdown_pin_n) |-> lo_q >= PD_LOW;
   endproperty
   a_pd_low_min: assert property (p_pd_low_min) else $error("powerdown pulse short");
   property p_no_lock_pd;
      !powerdown_pin_n [*4] |-> !lock;
   endproperty
   a_no_lock_pd: assert property (p_no_lock_pd) else $error("lock in powerdown");
   property p_lock_early;
      $rose(lock) |-> hi_q >= LOCK_DEV;
   endproperty
   a_lock_early: assert property (p_lock_early) else $error("lock too early");
   property p_soft_drop;
      powerdown_pin_n && soft_wr |=> !lock [*8];
   endproperty
   a_soft_drop: assert property (p_soft_drop) else $error("lock kept on soft reset");
   property p_eq_restart;
      $fell(lock) && !byp_q |-> ##[0:3] eq_level == EQ_RESET_LEVEL;
   endproperty
   a_eq_restart: assert property (p_eq_restart) else $error("level not restarted");
   property p_eq_manual;
      powerdown_pin_n && byp_q |-> eq_level == man_q;
   endproperty
   a_eq_manual: assert property (p_eq_manual) else $error("manual level not used");
   property p_recover;
      $fell(lock) && powerdown_pin_n && !$past(wr_stb) |-> ##[1:16] (!powerdown_pin_n || soft_wr);
   endproperty
   a_recover: assert property (p_recover) else $error("no recovery on loss");
   property p_timeout;
      wait_q <= LOCK_HOST + 16;
   endproperty
   a_timeout: assert property (p_timeout) else $error("lock wait not ended");

   c_lock: cover property ($rose(lock));
   c_soft: cover property (soft_wr);
   c_pd:   cover property ($fell(powerdown_pin_n));
endmodule

// >>> test/test_link_init.sv
`timescale 1ns/1ps
// drives both ends of the link bring-up pair and checks recovery
module test_deserializer_reset_link_init;
   import link_init_pkg::*;
   logic       sys_clk, rstn, supplies, use_soft, eq_man, sig_ok;
   logic [3:0] eq_lvl;
   logic       link_up, fail, soft_rst;
   logic [7:0] ctrl_reg;
   int         err_count, num_checks, cyc;

   link_init_if lnk();
   link_init_host #(.PD_LOW_CYCLES(10), .LOCK_CYCLES(700)) i_link_init_host
   (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .supplies_good_i(supplies),
      .use_soft_reset_i(use_soft), .eq_manual_i(eq_man), .eq_level_i(eq_lvl),
      .link_up_o(link_up), .fail_o(fail), .lnk(lnk)
   );
   link_init_device #(.LOCK_CYCLES(600)) i_link_init_device
   (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .signal_ok_i(sig_ok),
      .soft_rst_o(soft_rst), .ctrl_reg_o(ctrl_reg), .lnk(lnk)
   );
   link_init_sva i_link_init_sva
   (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .powerdown_pin_n(lnk.powerdown_pin_n),
      .lock(lnk.lock), .wr_stb(lnk.wr_stb), .wr_addr(lnk.wr_addr),
      .wr_data(lnk.wr_data), .eq_level(lnk.eq_level)
   );

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   // compare one value
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // bounded wait: 0 link up, 1 fail, 2 soft reset, 3 powerdown low
   task wait_for(input int sel, input int n);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++)
      begin
         @(posedge sys_clk);
         #1;
         case (sel)
            0: hit = link_up;
            1: hit = fail;
            2: hit = soft_rst;
            default: hit = !lnk.powerdown_pin_n;
         endcase
      end
      chk({7'h00, hit}, 8'h01);
   endtask

   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // counts and verdict
   task results();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         results();
      end
   end

   initial
   begin
      sys_clk = 0; rstn = 0; supplies = 0; use_soft = 0;
      eq_man = 0; eq_lvl = 4'hA; sig_ok = 1;
      step(8);
      rstn = 1;
      step(20);
      chk({7'h00, lnk.powerdown_pin_n}, 8'h00);
      supplies = 1;
      wait_for(0, 1000);
      $display("bring-up done");
      step(600);
      chk({7'h00, lnk.eq_level != 4'h0}, 8'h01);
      sig_ok = 0;
      step(6);
      chk({4'h0, lnk.eq_level}, 8'h00);
      chk({7'h00, lnk.lock}, 8'h00);
      wait_for(3, 20);
      wait_for(1, 1000);
      $display("loss and timeout done");
      use_soft = 1;
      wait_for(2, 1000);
      step(1);
      chk(ctrl_reg & 8'h02, 8'h00);
      eq_man = 1;
      sig_ok = 1;
      wait_for(0, 1000);
      step(2);
      chk({4'h0, lnk.eq_level}, 8'h0A);
      $display("soft recovery done");
      // short dropout: the soft reset pulse must still be ahead of the wait
      eq_lvl = 4'h5;
      sig_ok = 0;
      step(3);
      sig_ok = 1;
      wait_for(2, 50);
      step(3);
      chk({7'h00, link_up}, 8'h00);
      wait_for(0, 1000);
      step(2);
      chk({4'h0, lnk.eq_level}, 8'h05);
      $display("relock done");
      results();
   end
endmodule
